// ---- logic/bwic_top.sv ----
// bus wait and idle configuration registers with an access sequencer
`timescale 1ns/1ps
`default_nettype none
module bwic_top
    import bwic_pkg::*;
(
    input  wire logic        REF_CLK_I,
    input  wire logic        SYS_RST_I,
    input  wire logic [3:0]  REG_ADDR_I,
    input  wire logic [15:0] REG_WDATA_I,
    input  wire logic        REG_WR_I,
    input  wire logic        REG_RD_I,
    output logic      [15:0] REG_RDATA_O,
    input  wire logic        ACC_REQ_I,
    input  wire logic [2:0]  ACC_AREA_I,
    input  wire logic        ACC_WRITE_I,
    input  wire logic        ACC_DMA_SINGLE_I,
    input  wire logic        EXT_WAIT_I,
    output logic             ACC_READY_O,
    output logic             ACC_BUSY_O,
    output logic             ACC_DONE_O,
    output logic [3:0]       ACC_WAITS_O,
    output logic [1:0]       DMA_STROBE_WAITS_O,
    output logic             SDRAM_TWO_BANKS_O,
    output logic             DRAM_EDO_MODE_O,
    output logic             SDRAM_BURST_WRITE_O,
    output logic             EXT_WAIT_ENABLED_O
);
    // ----------------------------------------------------------------
    // register file
    // ----------------------------------------------------------------
    logic [15:0] bus_control_three_q;
    logic [15:0] wait_control_one_q;
    logic [15:0] wait_control_two_q;
    logic [15:0] bus_control_one_q;
    logic [15:0] area_config_q;
    logic [15:0] status_w;

    function automatic logic [15:0] merge(input logic [15:0] mask, input logic [15:0] data);
        merge = data & mask;
    endfunction

    // software writes; reserved bits stay zero
    // a write takes effect for the next request after its strobe
    always_ff @(posedge REF_CLK_I) begin
        if (SYS_RST_I) begin
            bus_control_three_q <= BWIC_RST_BUS_CONTROL_THREE;
            wait_control_one_q  <= BWIC_RST_WAIT_CONTROL_ONE;
            wait_control_two_q  <= BWIC_RST_WAIT_CONTROL_TWO;
            bus_control_one_q   <= BWIC_RST_BUS_CONTROL_ONE;
            area_config_q       <= BWIC_RST_AREA_CONFIG;
        end else if (REG_WR_I) begin
            case (REG_ADDR_I)
                BWIC_OFS_BUS_CONTROL_THREE:
                    bus_control_three_q <= merge(BWIC_WMASK_BUS_CONTROL_THREE, REG_WDATA_I);
                BWIC_OFS_WAIT_CONTROL_ONE:
                    wait_control_one_q <= merge(BWIC_WMASK_WAIT_CONTROL_ONE, REG_WDATA_I);
                BWIC_OFS_WAIT_CONTROL_TWO:
                    wait_control_two_q <= merge(BWIC_WMASK_WAIT_CONTROL_TWO, REG_WDATA_I);
                BWIC_OFS_BUS_CONTROL_ONE:
                    bus_control_one_q <= merge(BWIC_WMASK_BUS_CONTROL_ONE, REG_WDATA_I);
                BWIC_OFS_AREA_CONFIG:
                    area_config_q <= merge(BWIC_WMASK_AREA_CONFIG, REG_WDATA_I);
                default: ;
            endcase
        end
    end

    // read data one cycle after the strobe, zero otherwise
    always_ff @(posedge REF_CLK_I) begin
        if (SYS_RST_I) begin
            REG_RDATA_O <= 16'h0000;
        end else if (REG_RD_I) begin
            case (REG_ADDR_I)
                BWIC_OFS_BUS_CONTROL_THREE: REG_RDATA_O <= bus_control_three_q;
                BWIC_OFS_WAIT_CONTROL_ONE:  REG_RDATA_O <= wait_control_one_q;
                BWIC_OFS_WAIT_CONTROL_TWO:  REG_RDATA_O <= wait_control_two_q;
                BWIC_OFS_BUS_CONTROL_ONE:   REG_RDATA_O <= bus_control_one_q;
                BWIC_OFS_AREA_CONFIG:       REG_RDATA_O <= area_config_q;
                BWIC_OFS_STATUS:            REG_RDATA_O <= status_w;
                default:                    REG_RDATA_O <= 16'h0000;
            endcase
        end else begin
            REG_RDATA_O <= 16'h0000;
        end
    end

    // ----------------------------------------------------------------
    // area field extraction
    // ----------------------------------------------------------------
    logic [2:0] mem_type_w;
    logic       a2_sdram_w;
    logic       a3_sdram_w;
    logic       a3_dram_w;

    // memory kind of areas 2 and 3
    assign mem_type_w = area_config_q[BWIC_POS_MEM_TYPE +: 3];
    assign a3_sdram_w = (mem_type_w == BWIC_MEM_A3_SDRAM) || (mem_type_w == BWIC_MEM_BOTH_SDRAM);
    assign a2_sdram_w = (mem_type_w == BWIC_MEM_A2_SDRAM) || (mem_type_w == BWIC_MEM_BOTH_SDRAM);
    assign a3_dram_w  = (mem_type_w == BWIC_MEM_A3_DRAM);

    function automatic logic [1:0] area_wait(input logic [2:0] area,
                                             input logic [15:0] w1, input logic [15:0] w2);
        if (area == 3'h4) begin
            area_wait = w2[BWIC_POS_WAIT4 +: 2];
        end else begin
            area_wait = w1[BWIC_POS_WAIT + 2 * area[1:0] +: 2];
        end
    endfunction

    function automatic logic [1:0] area_idle(input logic [2:0] area,
                                             input logic [15:0] w1, input logic [15:0] w2);
        if (area == 3'h4) begin
            area_idle = w2[BWIC_POS_IDLE4 +: 2];
        end else begin
            area_idle = w1[BWIC_POS_IDLE + 2 * area[1:0] +: 2];
        end
    endfunction

    // idle code to cycle count: 0, 1, 2, 4
    function automatic logic [3:0] idle_cycles(input logic [1:0] code);
        case (code)
            2'h0:    idle_cycles = 4'h0;
            2'h1:    idle_cycles = 4'h1;
            2'h2:    idle_cycles = 4'h2;
            default: idle_cycles = BWIC_IDLE_MAX;
        endcase
    endfunction

    // three long-wait bits of an area; areas 2 and 3 share the high bit
    logic [2:0] lw_code_w;
    logic       lw_high_w;
    logic [4:0] lw_mid_sel_w;

    always_comb begin
        case (ACC_AREA_I)
            3'h0:    lw_high_w = bus_control_three_q[BWIC_POS_LW_HIGH];
            3'h1:    lw_high_w = bus_control_three_q[BWIC_POS_LW_HIGH + 1];
            3'h4:    lw_high_w = bus_control_three_q[BWIC_POS_LW_HIGH + 3];
            default: lw_high_w = bus_control_three_q[BWIC_POS_LW_HIGH_SH];
        endcase
    end
    assign lw_mid_sel_w = bus_control_one_q[4:0];
    // mid bit shared by all areas, low bit one per area in bus_control_one
    // area 4 has no low bit of its own and reuses that of area 3
    assign lw_code_w = {lw_high_w, lw_mid_sel_w[BWIC_POS_LW_MID + 4], 
                        lw_mid_sel_w[(ACC_AREA_I > 3'h3) ? 3'h3 : ACC_AREA_I]};

    // ----------------------------------------------------------------
    // decode of requested area
    // ----------------------------------------------------------------
    logic [3:0] dec_waits_w;
    logic       dec_ext_en_w;
    logic       req_sdram_w;
    logic       req_dram_w;
    logic       req_mask_w;

    assign req_sdram_w = ((ACC_AREA_I == 3'h2) && a2_sdram_w) ||
                         ((ACC_AREA_I == 3'h3) && a3_sdram_w);
    assign req_dram_w  = (ACC_AREA_I == 3'h3) && a3_dram_w;
    assign req_mask_w  = wait_control_two_q[BWIC_POS_WMASK + ACC_AREA_I];

    bwic_decode u_decode (
        .wait_field_i     (area_wait(ACC_AREA_I, wait_control_one_q, wait_control_two_q)),
        .long_wait_code_i (lw_code_w),
        .is_dram_i        (req_dram_w),
        .is_sdram_i       (req_sdram_w),
        .wait_mask_i      (req_mask_w),
        .wait_count_o     (dec_waits_w),
        .ext_wait_en_o    (dec_ext_en_w)
    );

    // ----------------------------------------------------------------
    // access sequencer: idle gap, then wait states
    // ----------------------------------------------------------------
    bwic_state_t state_q;
    logic [2:0]  prev_area_q;
    logic        prev_read_q;
    logic        prev_valid_q;
    logic [3:0]  cnt_q;
    logic        ext_en_q;
    logic [3:0]  gap_w;
    logic        need_gap_w;
    logic [1:0]  dsww_w;
    logic [3:0]  acc_waits_w;

    // a gap lets the last area let go of the data bus first;
    // its length follows the area accessed last, not the next one
    assign dsww_w     = bus_control_three_q[BWIC_POS_DSWW +: 2];
    assign need_gap_w = prev_valid_q && ((ACC_AREA_I != prev_area_q) ||
                        (prev_read_q && ACC_WRITE_I));
    assign gap_w      = idle_cycles(area_idle(prev_area_q, wait_control_one_q,
                                              wait_control_two_q));
    // DMA single writes to any area wait before the column strobe while area 3 is DRAM
    assign acc_waits_w = (ACC_DMA_SINGLE_I && ACC_WRITE_I && a3_dram_w) ?
                         {2'h0, dsww_w} + dec_waits_w : dec_waits_w;

    // state progression of a single access
    always_ff @(posedge REF_CLK_I) begin
        if (SYS_RST_I) begin
            state_q      <= BWIC_ST_IDLE;
            cnt_q        <= 4'h0;
            ext_en_q     <= 1'b0;
            prev_area_q  <= 3'h0;
            prev_read_q  <= 1'b0;
            prev_valid_q <= 1'b0;
            ACC_WAITS_O  <= 4'h0;
        end else begin
            case (state_q)
                BWIC_ST_IDLE: begin
                    if (ACC_REQ_I) begin
                        // remember this access for the gap of the next one
                        ACC_WAITS_O <= acc_waits_w;
                        ext_en_q    <= dec_ext_en_w;
                        prev_area_q <= ACC_AREA_I;
                        prev_read_q <= !ACC_WRITE_I;
                        prev_valid_q <= 1'b1;
                        if (need_gap_w && (gap_w != 4'h0)) begin
                            cnt_q   <= gap_w;
                            state_q <= BWIC_ST_GAP;
                        end else begin
                            cnt_q   <= acc_waits_w;
                            state_q <= BWIC_ST_WAIT;
                        end
                    end
                end
                // gap counts down to one, then loads the waits of this access
                BWIC_ST_GAP: begin
                    if (cnt_q == 4'h1) begin
                        cnt_q   <= ACC_WAITS_O;
                        state_q <= BWIC_ST_WAIT;
                    end else begin
                        cnt_q <= cnt_q - 4'h1;
                    end
                end
                // external wait stretches the access once the count is spent
                BWIC_ST_WAIT: begin
                    if (cnt_q != 4'h0) begin
                        cnt_q <= cnt_q - 4'h1;
                    end else if (!(ext_en_q && EXT_WAIT_I)) begin
                        state_q <= BWIC_ST_IDLE;
                    end
                end
                default: state_q <= BWIC_ST_IDLE;
            endcase
        end
    end

    // end-of-access pulse, same condition that returns to idle
    always_ff @(posedge REF_CLK_I) begin
        if (SYS_RST_I) begin
            ACC_DONE_O <= 1'b0;
        end else begin
            ACC_DONE_O <= (state_q == BWIC_ST_WAIT) && (cnt_q == 4'h0) &&
                          !(ext_en_q && EXT_WAIT_I);
        end
    end

    // busy from the request edge until the access ends
    always_ff @(posedge REF_CLK_I) begin
        if (SYS_RST_I) begin
            ACC_BUSY_O <= 1'b0;
        end else begin
            ACC_BUSY_O <= (state_q != BWIC_ST_IDLE) || ACC_REQ_I;
        end
    end

    // ready only while idle with no request pending
    always_ff @(posedge REF_CLK_I) begin
        if (SYS_RST_I) begin
            ACC_READY_O <= 1'b0;
        end else begin
            ACC_READY_O <= (state_q == BWIC_ST_IDLE) && !ACC_REQ_I;
        end
    end

    // external wait enable: requested area when idle, latched after
    always_ff @(posedge REF_CLK_I) begin
        if (SYS_RST_I) begin
            EXT_WAIT_ENABLED_O <= 1'b0;
        end else begin
            EXT_WAIT_ENABLED_O <= (state_q == BWIC_ST_IDLE) ? dec_ext_en_w : ext_en_q;
        end
    end

    // DMA single write wait code, shown only for area 3 DRAM
    always_ff @(posedge REF_CLK_I) begin
        if (SYS_RST_I) begin
            DMA_STROBE_WAITS_O <= 2'h0;
        end else begin
            DMA_STROBE_WAITS_O <= a3_dram_w ? dsww_w : 2'h0;
        end
    end

    // bank count of 64M synchronous DRAM
    always_ff @(posedge REF_CLK_I) begin
        if (SYS_RST_I) begin
            SDRAM_TWO_BANKS_O <= 1'b0;
        end else begin
            SDRAM_TWO_BANKS_O <= area_config_q[BWIC_POS_SDRAM64] &&
                                 bus_control_three_q[BWIC_POS_BANK_SEL];
        end
    end

    // page mode or extended data out for area 3 DRAM
    always_ff @(posedge REF_CLK_I) begin
        if (SYS_RST_I) begin
            DRAM_EDO_MODE_O <= 1'b0;
        end else begin
            DRAM_EDO_MODE_O <= a3_dram_w && bus_control_three_q[BWIC_POS_EDO_SEL];
        end
    end

    // burst or single writes for synchronous DRAM areas
    always_ff @(posedge REF_CLK_I) begin
        if (SYS_RST_I) begin
            SDRAM_BURST_WRITE_O <= 1'b0;
        end else begin
            SDRAM_BURST_WRITE_O <= (a2_sdram_w || a3_sdram_w) &&
                                   bus_control_three_q[BWIC_POS_BURST_SEL];
        end
    end

    // status: last area, whether one was seen, sequencer state
    assign status_w = {8'h00, prev_valid_q, prev_area_q, 2'h0, state_q};
endmodule : bwic_top
`default_nettype wire

// ---- logic/bwic_pkg.sv ----
// constants, register layout and reset values of the bus wait and idle configuration block
package bwic_pkg;
    // ----------------------------------------------------------------
    // register offsets (word index on the plain register port)
    // ----------------------------------------------------------------
    localparam logic [3:0] BWIC_OFS_BUS_CONTROL_THREE = 4'h0;
    localparam logic [3:0] BWIC_OFS_WAIT_CONTROL_ONE  = 4'h1;
    localparam logic [3:0] BWIC_OFS_WAIT_CONTROL_TWO  = 4'h2;
    localparam logic [3:0] BWIC_OFS_BUS_CONTROL_ONE   = 4'h3;
    localparam logic [3:0] BWIC_OFS_AREA_CONFIG       = 4'h4;
    localparam logic [3:0] BWIC_OFS_STATUS            = 4'h5;

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [15:0] BWIC_RST_BUS_CONTROL_THREE = 16'h0f00;
    localparam logic [15:0] BWIC_RST_WAIT_CONTROL_ONE  = 16'haaff;
    localparam logic [15:0] BWIC_RST_WAIT_CONTROL_TWO  = 16'h000b;
    localparam logic [15:0] BWIC_RST_BUS_CONTROL_ONE   = 16'h001f;
    localparam logic [15:0] BWIC_RST_AREA_CONFIG       = 16'h0000;

    // ----------------------------------------------------------------
    // writable bit masks (reserved bits hold zero)
    // ----------------------------------------------------------------
    localparam logic [15:0] BWIC_WMASK_BUS_CONTROL_THREE = 16'h0fc7;
    localparam logic [15:0] BWIC_WMASK_WAIT_CONTROL_ONE  = 16'hffff;
    localparam logic [15:0] BWIC_WMASK_WAIT_CONTROL_TWO  = 16'hdf0f;
    localparam logic [15:0] BWIC_WMASK_BUS_CONTROL_ONE   = 16'h001f;
    localparam logic [15:0] BWIC_WMASK_AREA_CONFIG       = 16'h000f;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int BWIC_POS_LW_HIGH     = 8;  // bus_control_three, one bit each for areas 0, 1 and 4
    localparam int BWIC_POS_LW_HIGH_SH  = 10; // shared high bit of areas 2 and 3
    localparam int BWIC_POS_DSWW        = 6;
    localparam int BWIC_POS_BANK_SEL    = 2;
    localparam int BWIC_POS_EDO_SEL     = 1;
    localparam int BWIC_POS_BURST_SEL   = 0;
    localparam int BWIC_POS_IDLE        = 8;  // wait_control_one, two bits per area
    localparam int BWIC_POS_WAIT        = 0;
    localparam int BWIC_POS_WMASK       = 8;  // wait_control_two
    localparam int BWIC_POS_IDLE4       = 2;
    localparam int BWIC_POS_WAIT4       = 0;
    localparam int BWIC_POS_LW_MID      = 0;  // bus_control_one, one low bit each for areas 0 to 3, mid bit at +4 shared by all
    localparam int BWIC_POS_MEM_TYPE    = 0;  // area_config
    localparam int BWIC_POS_SDRAM64     = 3;

    // ----------------------------------------------------------------
    // area memory types
    // ----------------------------------------------------------------
    localparam logic [2:0] BWIC_MEM_ORDINARY   = 3'h0;
    localparam logic [2:0] BWIC_MEM_A3_SDRAM   = 3'h1;
    localparam logic [2:0] BWIC_MEM_A3_DRAM    = 3'h2;
    localparam logic [2:0] BWIC_MEM_A2_SDRAM   = 3'h4;
    localparam logic [2:0] BWIC_MEM_BOTH_SDRAM = 3'h5;

    localparam logic [1:0] BWIC_WAIT_LONG = 2'h3;
    localparam logic [3:0] BWIC_IDLE_MAX  = 4'h4;

    typedef enum logic [1:0] {
        BWIC_ST_IDLE,
        BWIC_ST_GAP,
        BWIC_ST_WAIT
    } bwic_state_t;
endpackage : bwic_pkg

// ---- logic/bwic_decode.sv ----
// decode of one area's wait settings into wait count and external wait enable
`timescale 1ns/1ps
`default_nettype none
module bwic_decode
    import bwic_pkg::*;
(
    input  wire logic [1:0] wait_field_i,
    input  wire logic [2:0] long_wait_code_i,
    input  wire logic       is_dram_i,
    input  wire logic       is_sdram_i,
    input  wire logic       wait_mask_i,
    output logic      [3:0] wait_count_o,
    output logic            ext_wait_en_o
);
    // ----------------------------------------------------------------
    // long wait table
    // ----------------------------------------------------------------
    function automatic logic [3:0] long_wait_cycles(input logic [2:0] code);
        case (code)
            3'h0:    long_wait_cycles = 4'h3;
            3'h1:    long_wait_cycles = 4'h4;
            3'h2:    long_wait_cycles = 4'h5;
            3'h3:    long_wait_cycles = 4'h6;
            3'h4:    long_wait_cycles = 4'h8;
            3'h5:    long_wait_cycles = 4'ha;
            3'h6:    long_wait_cycles = 4'hc;
            default: long_wait_cycles = 4'he;
        endcase
    endfunction

    // wait count: column strobe length, latency, or ordinary wait
    always_comb begin
        if (is_sdram_i) begin
            wait_count_o  = {2'h0, wait_field_i} + 4'h1;
            ext_wait_en_o = 1'b0;
        end else if (is_dram_i) begin
            wait_count_o  = {2'h0, wait_field_i} + 4'h1;
            ext_wait_en_o = !wait_mask_i && (wait_field_i != 2'h0);
        end else begin
            if (wait_field_i == BWIC_WAIT_LONG) begin
                wait_count_o = long_wait_cycles(long_wait_code_i);
            end else begin
                wait_count_o = {2'h0, wait_field_i};
            end
            ext_wait_en_o = !wait_mask_i && (wait_field_i != 2'h0);
        end
    end
endmodule : bwic_decode
`default_nettype wire

// ---- dv/bwic_ext_mem.sv ----
// far-side memory model that stretches accesses with its wait line
`timescale 1ns/1ps
`default_nettype none
module bwic_ext_mem (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       busy_i,
    input  wire logic [3:0] stall_i,
    output logic            wait_o
);
    logic [3:0] cnt_q;
    logic       busy_q;
    // -------------------------------------------
    // wait held for stall_i cycles per access
    // -------------------------------------------
    always_ff @(posedge clk_i) begin
        busy_q <= busy_i;
        if (rst_i)
            cnt_q <= 4'h0;
        else if (busy_i && !busy_q)
            cnt_q <= stall_i; // zero answers promptly
        else if (cnt_q != 4'h0)
            cnt_q <= cnt_q - 4'h1;
    end
    assign wait_o = (cnt_q != 4'h0);
endmodule // bwic_ext_mem
`default_nettype wire

// ---- dv/bwic_monitor.sv ----
// port checker of the wait and idle configuration block
`timescale 1ns/1ps
`default_nettype none
module bwic_monitor (
    input wire logic        REF_CLK_I,
    input wire logic        SYS_RST_I,
    input wire logic [3:0]  REG_ADDR_I,
    input wire logic [15:0] REG_WDATA_I,
    input wire logic        REG_WR_I,
    input wire logic        REG_RD_I,
    input wire logic [15:0] REG_RDATA_O,
    input wire logic        ACC_REQ_I,
    input wire logic [2:0]  ACC_AREA_I,
    input wire logic        ACC_READY_O,
    input wire logic        ACC_DONE_O,
    input wire logic [1:0]  DMA_STROBE_WAITS_O,
    input wire logic        SDRAM_TWO_BANKS_O,
    input wire logic        DRAM_EDO_MODE_O,
    input wire logic        EXT_WAIT_ENABLED_O
);
    default clocking cb @(posedge REF_CLK_I); endclocking
    default disable iff (SYS_RST_I);
    logic [15:0] bc3_q, wc1_q, wc2_q;
    logic [3:0]  cfg_q;
    logic [2:0]  area_q;
    // -------------------------------------------
    // shadow of registers and latest area
    // -------------------------------------------
    always_ff @(posedge REF_CLK_I) begin
        if (SYS_RST_I) begin
            bc3_q <= 16'h0f00;
            wc1_q <= 16'haaff;
            wc2_q <= 16'h000b;
            cfg_q <= 4'h0;
            area_q <= 3'h0;
        end else begin
            if (REG_WR_I && REG_ADDR_I == 4'h0) bc3_q <= REG_WDATA_I;
            if (REG_WR_I && REG_ADDR_I == 4'h1) wc1_q <= REG_WDATA_I;
            if (REG_WR_I && REG_ADDR_I == 4'h2) wc2_q <= REG_WDATA_I;
            if (REG_WR_I && REG_ADDR_I == 4'h4) cfg_q <= REG_WDATA_I[3:0];
            if (ACC_REQ_I && ACC_READY_O) area_q <= ACC_AREA_I;
        end
    end
    wire logic sd = (area_q == 3'h3 && cfg_q[2:0] inside {3'h1, 3'h5}) || (area_q == 3'h2 && cfg_q[2]);
    wire logic dr = (area_q == 3'h3 && cfg_q[2:0] == 3'h2);
    wire logic [1:0] fld = (area_q == 3'h4) ? wc2_q[1:0] : wc1_q[{area_q[1:0], 1'b0} +: 2];
    sequence s_take; ACC_REQ_I && ACC_READY_O; endsequence
    sequence s_end; ACC_DONE_O; endsequence
    property p_rsv; REG_RD_I && REG_ADDR_I == 4'h0 |=> REG_RDATA_O[5:3] == 3'h0; endproperty
    property p_take; s_take |=> !ACC_DONE_O; endproperty
    property p_edo; REG_WR_I && REG_ADDR_I == 4'h0 && REG_WDATA_I[1] && cfg_q[2:0] == 3'h2
        |-> ##[1:2] DRAM_EDO_MODE_O; endproperty
    property p_banks; REG_WR_I && REG_ADDR_I == 4'h0 && REG_WDATA_I[2] && cfg_q[3]
        |-> ##[1:2] SDRAM_TWO_BANKS_O; endproperty
    property p_dma; s_end and dr |-> DMA_STROBE_WAITS_O == bc3_q[7:6]; endproperty
    property p_sd; s_end and sd |-> !EXT_WAIT_ENABLED_O; endproperty
    property p_mask; s_end and wc2_q[{1'b1, area_q}] |-> !EXT_WAIT_ENABLED_O; endproperty
    property p_none; s_end and !sd and fld == 2'h0 |-> !EXT_WAIT_ENABLED_O; endproperty
    property p_dram; s_end and dr and fld != 2'h0 and !wc2_q[11] |-> EXT_WAIT_ENABLED_O;
    endproperty
    a_rsv: assert property (p_rsv) else $error("reserved bits read nonzero");
    a_take: assert property (p_take) else $error("access ended too soon");
    a_edo: assert property (p_edo) else $error("edo mode not shown");
    a_banks: assert property (p_banks) else $error("two banks not shown");
    a_dma: assert property (p_dma) else $error("dma wait code wrong");
    a_sd: assert property (p_sd) else $error("sdram honours wait");
    a_mask: assert property (p_mask) else $error("masked wait honoured");
    a_none: assert property (p_none) else $error("wait honoured at code 00");
    a_dram: assert property (p_dram) else $error("dram wait not honoured");
endmodule // bwic_monitor
bind bwic_top bwic_monitor u_mon (.*);
`default_nettype wire

// ---- dv/tb_bus_wait_idle_config.sv ----
// self-checking bench of the wait and idle configuration block
`timescale 1ns/1ps
`default_nettype none
module tb_bus_wait_idle_config;
    logic        clk, rst, wr, rd, req, wrt, dma, ew, rdy, busy, done, ewen, two, extended_data_out_select, burst;
    logic [3:0]  addr, stall, waits;
    logic [15:0] wdata, rdata, v;
    logic [2:0]  area;
    logic [1:0]  dmaw, f;
    int          num_errors, tests_run, lat, i;
    bwic_top u_dut (.REF_CLK_I(clk), .SYS_RST_I(rst), .REG_ADDR_I(addr), .REG_WDATA_I(wdata),
        .REG_WR_I(wr), .REG_RD_I(rd), .REG_RDATA_O(rdata), .ACC_REQ_I(req), .ACC_AREA_I(area),
        .ACC_WRITE_I(wrt), .ACC_DMA_SINGLE_I(dma), .EXT_WAIT_I(ew), .ACC_READY_O(rdy),
        .ACC_BUSY_O(busy), .ACC_DONE_O(done), .ACC_WAITS_O(waits), .DMA_STROBE_WAITS_O(dmaw),
        .SDRAM_TWO_BANKS_O(two), .DRAM_EDO_MODE_O(extended_data_out_select), .SDRAM_BURST_WRITE_O(burst),
        .EXT_WAIT_ENABLED_O(ewen));
    bwic_ext_mem u_mem (.clk_i(clk), .rst_i(rst), .busy_i(busy), .stall_i(stall), .wait_o(ew));
    // -------------------------------------------
    // compare, bus and access tasks
    // -------------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk_min(input int got, input int lo);
        tests_run++;
        if (got < lo) begin
            num_errors++;
            $display("MISMATCH t=%0t latency %0d below %0d", $time, got, lo);
        end
    endtask
    task automatic end_of_test;
        $display("errors %0d checks %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic wreg(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rreg(input logic [3:0] a);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 v = rdata;
    endtask
    task automatic acc(input logic [2:0] a, input logic w, input logic d);
        int n;
        n = 0;
        while (rdy !== 1'b1 && n < 60) begin
            @(posedge clk);
            #1 n++;
        end
        @(posedge clk);
        req <= 1'b1;
        area <= a;
        wrt <= w;
        dma <= d;
        @(posedge clk);
        req <= 1'b0;
        lat = 1;
        #1;
        while (done !== 1'b1 && lat < 60) begin
            @(posedge clk);
            #1 lat++;
        end
        if (lat >= 60 || n >= 60) begin
            num_errors++;
            $display("MISMATCH t=%0t access hung", $time);
            end_of_test();
        end
    endtask
    function automatic logic [3:0] exp_wait(input logic [1:0] c, input logic [2:0] lw);
        if (c != 2'h3) return {2'h0, c};
        return lw[2] ? 4'h8 + {lw[1:0], 1'b0} : 4'h3 + {2'h0, lw[1:0]};
    endfunction
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // -------------------------------------------
    // main sequence
    // -------------------------------------------
    initial begin
        {rst, wr, rd, req, wrt, dma, addr, wdata, area, stall} = '0;
        rst = 1'b1;
        void'($urandom(32'hbcef));
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        rreg(4'h0); chk(v, 16'h0f00);
        rreg(4'h1); chk(v, 16'haaff);
        rreg(4'h2); chk(v, 16'h000b);
        rreg(4'hf); chk(v, 16'h0000);
        wreg(4'h0, 16'hffbf); rreg(4'h0); chk(v, 16'h0f87);
        wreg(4'h2, 16'hbfff); rreg(4'h2); chk(v, 16'h9f0f);
        wreg(4'h2, 16'h0000); // registers set before any access
        for (i = 0; i < 4; i++) begin
            wreg(4'h3, i[0] ? 16'h001f : 16'h0000);
            wreg(4'h0, i[1] ? 16'h0f00 : 16'h0000);
            acc(3'h0, 1'b0, 1'b0);
            chk(waits, exp_wait(2'h3, {i[1], i[0], i[0]}));
        end
        repeat (6) begin
            f = 2'($urandom_range(2, 0));
            wreg(4'h1, {8'h00, f, f, f, f});
            acc(3'($urandom_range(1, 0)), 1'($urandom_range(1, 0)), 1'b0);
            chk(waits, exp_wait(f, 3'h0));
            chk(ewen, f != 2'h0);
        end
        wreg(4'h1, 16'h0005);
        stall <= 4'h5;
        acc(3'h0, 1'b0, 1'b0);
        chk_min(lat, 6);
        stall <= 4'h0;
        wreg(4'h2, 16'h0200);
        acc(3'h1, 1'b0, 1'b0);
        chk(ewen, 1'b0);
        wreg(4'h1, 16'h0300);
        acc(3'h1, 1'b0, 1'b0);
        acc(3'h0, 1'b0, 1'b0);
        acc(3'h1, 1'b0, 1'b0);
        chk_min(lat, 5);
        acc(3'h0, 1'b0, 1'b0);
        acc(3'h0, 1'b1, 1'b0);
        chk_min(lat, 5);
        wreg(4'h2, 16'h0000);
        wreg(4'h4, 16'h0002);
        wreg(4'h0, 16'h0042);
        for (i = 0; i < 3; i++) begin
            wreg(4'h1, {8'h00, i[1:0], 6'h00});
            acc(3'h3, 1'b1, 1'b0);
            chk(waits, 4'(i + 1));
            chk(ewen, i != 0);
            chk(extended_data_out_select, 1'b1);
            chk(dmaw, 2'h1);
        end
        acc(3'h3, 1'b1, 1'b1);
        chk(waits, 4'h4);
        wreg(4'h4, 16'h000d);
        wreg(4'h0, 16'h0005);
        for (i = 0; i < 4; i++) begin
            wreg(4'h1, {8'h00, i[1:0], i[1:0], 4'h0});
            acc(3'(2 + i % 2), 1'b1, 1'b0);
            chk(waits, 4'(i + 1));
            chk(ewen, 1'b0);
            chk(burst, 1'b1);
            chk(two, 1'b1);
        end
        wreg(4'h2, 16'h0003);
        acc(3'h4, 1'b0, 1'b0);
        chk(waits, exp_wait(2'h3, 3'h3));
        end_of_test();
    end
endmodule // tb_bus_wait_idle_config
`default_nettype wire
